/* File: hdl/tw_master.sv */
// Two-wire master transmit controller with Wishbone registers
module tw_master
	import tw_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        global_irq_enable,
	output logic             irq,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_n,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n
);
	tw_bit_if bits ();

	logic       flag;
	logic       enable;
	logic       local_irq_enable;
	logic [7:0] shift_data_reg;
	logic [7:0] bit_rate;
	logic [4:0] status_code;
	logic [4:0] status_q;
	logic       flag_q;
	tw_state_t  state;
	logic [1:0] phase;
	logic [2:0] bitn;
	logic       scl_low;
	logic       sda_low;
	logic       addr_phase;
	logic       rx_ack;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic       pending_start;
	logic       pending_stop;
	logic       pending_byte;

	// Bus slave decode
	wire req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Writes land on the edge that ends the cycle
	wire wr       = wb_cyc_i && wb_stb_i && wb_ack_o &&
	                wb_we_i && wb_sel_i[0];
	wire wr_ctrl  = wr && (wb_adr_i == TW_ADDR_CTRL);
	wire wr_data  = wr && (wb_adr_i == TW_ADDR_DATA);
	wire wr_bitrt = wr && (wb_adr_i == TW_ADDR_BITRT);
	wire clr_flag = wr_ctrl && wb_dat_i[TW_CTRL_FLAG];
	wire set_flag;

	// Status shows idle code when flag_q (flag one cycle late) is clear
	wire [7:0] status_rd = flag_q ? {status_q, 3'b000}
	                              : {TW_ST_NONE, 3'b000};
	wire [7:0] ctrl_rd   = {flag, 4'h0, enable, 1'b0, local_irq_enable};
	wire [7:0] rd_mux    =
		(wb_adr_i == TW_ADDR_CTRL)   ? ctrl_rd :
		(wb_adr_i == TW_ADDR_STATUS) ? status_rd :
		(wb_adr_i == TW_ADDR_DATA)   ? shift_data_reg :
		(wb_adr_i == TW_ADDR_BITRT)  ? bit_rate : 8'h00;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= {24'h0, rd_mux};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			enable           <= 1'b0;
			local_irq_enable <= 1'b0;
			bit_rate         <= TW_BITRT_RESET;
		end else begin
			if (wr_ctrl) begin
				enable           <= wb_dat_i[TW_CTRL_EN];
				local_irq_enable <= wb_dat_i[TW_CTRL_IE];
			end
			if (wr_bitrt)
				bit_rate <= wb_dat_i[7:0];
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			flag <= 1'b0;
		else if (set_flag)
			flag <= 1'b1;
		else if (clr_flag)
			flag <= 1'b0;
	end

	// Status follows one cycle behind the flag
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flag_q   <= 1'b0;
			status_q <= TW_ST_NONE;
		end else begin
			flag_q <= flag;
			if (flag && !flag_q)
				status_q <= status_code;
		end
	end

	assign irq = flag && local_irq_enable && global_irq_enable;

	// Command latched only by the clearing write
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pending_start <= 1'b0;
			pending_stop  <= 1'b0;
			pending_byte  <= 1'b0;
		end else if (clr_flag && wb_dat_i[TW_CTRL_EN]) begin
			pending_start <= wb_dat_i[TW_CTRL_START];
			pending_stop  <= wb_dat_i[TW_CTRL_STOP] &&
			                 !wb_dat_i[TW_CTRL_START];
			pending_byte  <= !wb_dat_i[TW_CTRL_START] &&
			                 !wb_dat_i[TW_CTRL_STOP];
		end else if (state != TW_IDLE && state != TW_WAIT) begin
			pending_start <= 1'b0;
			pending_stop  <= 1'b0;
			pending_byte  <= 1'b0;
		end
	end

	// Shift register loads in any state except TW_SHIFT
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			shift_data_reg <= TW_DATA_RESET;
		else if (wr_data && state != TW_SHIFT)
			shift_data_reg <= wb_dat_i[7:0];
		else if (state == TW_SHIFT && bits.tick && phase == 2'd3)
			shift_data_reg <= {shift_data_reg[6:0], shift_data_reg[7]};
	end

	// Pins come from another domain
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
		end
	end

	// Slave may stretch: hold phase 2 while released clock reads low
	wire stretched = !scl_low && !scl_sync[1] && phase == 2'd2;
	wire go        = bits.tick && !stretched;
	wire busy_ok   = !flag;
	assign bits.run = state != TW_IDLE && state != TW_WAIT;

	wire ev_start = state == TW_START && go && phase == 2'd3;
	wire ev_byte  = state == TW_ACK && go && phase == 2'd3;
	assign set_flag = ev_start || ev_byte;

	assign status_code =
		!addr_phase ? TW_ST_START :
		(addr_phase && bitn == 3'd0 && rx_ack == 1'b0) ? TW_ST_ADDR_ACK :
		(bitn == 3'd0) ? TW_ST_ADDR_NAK :
		rx_ack ? TW_ST_DATA_NAK : TW_ST_DATA_ACK;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state      <= TW_IDLE;
			phase      <= 2'd0;
			bitn       <= 3'd0;
			scl_low    <= 1'b0;
			sda_low    <= 1'b0;
			addr_phase <= 1'b0;
			rx_ack     <= 1'b1;
		end else begin
			case (state)
			TW_IDLE, TW_WAIT: begin
				phase <= 2'd0;
				if (busy_ok && pending_start) begin
					state   <= TW_START;
					scl_low <= 1'b0;
					sda_low <= 1'b0;
				end else if (busy_ok && pending_byte &&
				             state == TW_WAIT) begin
					state <= TW_SHIFT;
					bitn  <= 3'd7;
				end else if (busy_ok && pending_stop &&
				             state == TW_WAIT) begin
					state <= TW_STOP;
				end
			end
			TW_START: if (go) begin
				phase <= phase + 2'd1;
				if (phase == 2'd1)
					sda_low <= 1'b1;
				if (phase == 2'd3) begin
					scl_low    <= 1'b1;
					addr_phase <= 1'b0;
					bitn       <= 3'd1;
					state      <= TW_WAIT;
				end
			end
			TW_SHIFT: if (go) begin
				phase <= phase + 2'd1;
				if (phase == 2'd0)
					sda_low <= !shift_data_reg[7];
				if (phase == 2'd1)
					scl_low <= 1'b0;
				if (phase == 2'd3) begin
					scl_low <= 1'b1;
					bitn    <= bitn - 3'd1;
					if (bitn == 3'd0)
						state <= TW_ACK;
				end
			end
			TW_ACK: if (go) begin
				phase <= phase + 2'd1;
				if (phase == 2'd0)
					sda_low <= 1'b0;
				if (phase == 2'd1)
					scl_low <= 1'b0;
				if (phase == 2'd2)
					rx_ack <= sda_sync[1];
				if (phase == 2'd3) begin
					scl_low    <= 1'b1;
					addr_phase <= 1'b1;
					bitn       <= addr_phase ? 3'd1 : 3'd0;
					state      <= TW_WAIT;
				end
			end
			TW_STOP: if (go) begin
				phase <= phase + 2'd1;
				if (phase == 2'd0)
					sda_low <= 1'b1;
				if (phase == 2'd1)
					scl_low <= 1'b0;
				if (phase == 2'd3) begin
					sda_low <= 1'b0;
					state   <= TW_IDLE;
				end
			end
			default: state <= TW_IDLE;
			endcase
		end
	end

	tw_bitgen u_bitgen (
		.clock (clock),
		.rstn  (rstn),
		.div   (bit_rate),
		.bits  (bits)
	);

	// Open drain: enable low drives the pin low
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_n = !(scl_low || (flag && state == TW_WAIT));
	assign sda_oe_n = !sda_low;

	a_irq_gate: assert property (
		@(posedge clock) disable iff (!rstn)
		irq |-> flag && local_irq_enable && global_irq_enable)
		else $error("irq without flag and enables");

	a_flag_event: assert property (
		@(posedge clock) disable iff (!rstn)
		set_flag |=> flag)
		else $error("flag not set by bus event");

	a_clear_flag: assert property (
		@(posedge clock) disable iff (!rstn)
		clr_flag && !set_flag |=> !flag)
		else $error("flag not cleared");

	a_hold_flag: assert property (
		@(posedge clock) disable iff (!rstn)
		flag && !clr_flag |=> flag)
		else $error("flag dropped without clear");

	a_no_op_flag: assert property (
		@(posedge clock) disable iff (!rstn)
		flag && $past(flag) |-> state == TW_WAIT || state == TW_IDLE)
		else $error("operation began while flag set");

	a_wait_quiet: assert property (
		@(posedge clock) disable iff (!rstn)
		flag |-> !bits.run)
		else $error("bit engine runs while flag set");

	a_start_code: assert property (
		@(posedge clock) disable iff (!rstn)
		ev_start |-> ##2 status_q == TW_ST_START)
		else $error("start code not posted");

	a_addr_ack: assert property (
		@(posedge clock) disable iff (!rstn)
		ev_byte && !addr_phase && !rx_ack
		|-> ##2 status_q == TW_ST_ADDR_ACK)
		else $error("address ack code not posted");

	a_data_nak: assert property (
		@(posedge clock) disable iff (!rstn)
		ev_byte && addr_phase && rx_ack
		|-> ##2 status_q == TW_ST_DATA_NAK)
		else $error("data nak code not posted");

	a_scl_held: assert property (
		@(posedge clock) disable iff (!rstn)
		flag |-> scl_low && !scl_oe_n)
		else $error("clock released while flag set");

	a_byte_exact: assert property (
		@(posedge clock) disable iff (!rstn)
		state == TW_WAIT && pending_byte && !flag |=> state == TW_SHIFT)
		else $error("byte transfer not begun");

	a_stop_exact: assert property (
		@(posedge clock) disable iff (!rstn)
		state == TW_WAIT && pending_stop && !flag |=> state == TW_STOP)
		else $error("stop not begun");

	a_status_valid: assert property (
		@(posedge clock) disable iff (!rstn)
		flag_q |-> status_q != TW_ST_NONE)
		else $error("no bus state while flag set");

	a_status_next: assert property (
		@(posedge clock) disable iff (!rstn)
		$rose(flag) |=> status_q == $past(status_code))
		else $error("status not loaded after flag");

	a_status_idle: assert property (
		@(posedge clock) disable iff (!rstn)
		req && !wb_we_i && wb_adr_i == TW_ADDR_STATUS && !flag_q
		|=> wb_dat_o == {24'h0, TW_ST_NONE, 3'b000})
		else $error("idle code missing");

	a_stop_noflag: assert property (
		@(posedge clock) disable iff (!rstn)
		state == TW_STOP ##1 state == TW_IDLE |-> !flag ##1 !flag)
		else $error("flag set after stop");

	a_start_begin: assert property (
		@(posedge clock) disable iff (!rstn)
		state == TW_IDLE && pending_start && !flag |=> state == TW_START)
		else $error("start not begun");

	a_irq_drop: assert property (
		@(posedge clock) disable iff (!rstn)
		clr_flag && !set_flag |=> !irq)
		else $error("irq stays after clear");
endmodule

/* File: hdl/tw_pkg.sv */
// Constants and types for the two-wire master transmit controller
package tw_pkg;
	localparam logic [7:0] TW_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] TW_ADDR_STATUS = 8'h04;
	localparam logic [7:0] TW_ADDR_DATA   = 8'h08;
	localparam logic [7:0] TW_ADDR_BITRT  = 8'h0c;
	localparam int TW_CTRL_FLAG  = 7;
	localparam int TW_CTRL_START = 5;
	localparam int TW_CTRL_STOP  = 4;
	localparam int TW_CTRL_EN    = 2;
	localparam int TW_CTRL_IE    = 0;
	localparam logic [4:0] TW_ST_START    = 5'h01;
	localparam logic [4:0] TW_ST_ADDR_ACK = 5'h03;
	localparam logic [4:0] TW_ST_ADDR_NAK = 5'h04;
	localparam logic [4:0] TW_ST_DATA_ACK = 5'h05;
	localparam logic [4:0] TW_ST_DATA_NAK = 5'h06;
	localparam logic [4:0] TW_ST_NONE     = 5'h1f;
	localparam logic [7:0] TW_BITRT_RESET = 8'h04;
	localparam logic [7:0] TW_DATA_RESET  = 8'hff;
	typedef enum logic [2:0] {
		TW_IDLE  = 3'b000,
		TW_START = 3'b001,
		TW_SHIFT = 3'b011,
		TW_ACK   = 3'b010,
		TW_WAIT  = 3'b110,
		TW_STOP  = 3'b111
	} tw_state_t;
endpackage

/* File: hdl/tw_if.sv */
// Bit timing handshake between controller and bit engine
interface tw_bit_if;
	logic       tick;
	logic       run;
	modport ctrl (input tick, output run);
	modport gen  (output tick, input run);
endinterface

/* File: hdl/tw_bitgen.sv */
// Quarter-bit tick divider for the bus clock
module tw_bitgen
	import tw_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [7:0] div,
	tw_bit_if.gen           bits
);
	logic [7:0] cnt;
	wire        hit = (cnt >= div);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			cnt <= 8'h00;
		else if (!bits.run || hit)
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
	end

	assign bits.tick = bits.run && hit;
endmodule

/* File: tb/tw_slave.sv */
// Behavioural slave on the two-wire bus for the master bench
module tw_slave (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       nak,
	output logic            sda_oe_n,
	output logic [7:0]      rx,
	output logic            stop_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bitn = 0;
	initial begin
		sda_oe_n = 1'b1;
		rx = 8'h00;
		stop_seen = 1'b0;
	end
	always @(negedge sda) begin
		if (scl) begin
			bitn = 0;
			stop_seen = 1'b0;
		end
	end
	always @(posedge sda) begin
		if (scl)
			stop_seen = 1'b1;
	end
	// Byte arrives most significant bit first
	always @(posedge scl) begin
		if (bitn < 8)
			rx = {rx[6:0], sda};
		bitn++;
	end
	// Ack driven only while scl is low, so no false stop
	always @(negedge scl) begin
		if (bitn == 8)
			sda_oe_n = nak;
		else if (bitn == 9) begin
			sda_oe_n = 1'b1;
			bitn = 0;
		end
	end
endmodule

/* File: tb/tb_tw_master.sv */
// Self-checking bench for the two-wire master transmit controller
module tb_tw_master
	import tw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic        gie = 1'b0;
	logic        nak = 1'b0;
	logic        ie;
	wire  [31:0] rdat;
	wire         ack, irq, scl_oe_n, sda_oe_n, s_oe_n, stop_seen;
	wire         scl_o, sda_o;
	wire  [7:0]  rx;
	// Pull-ups: a released line reads high
	wire         scl = scl_oe_n ? 1'b1 : scl_o;
	wire         sda = (sda_oe_n ? 1'b1 : sda_o) & s_oe_n;
	int          error_cnt = 0;
	int          checks = 0;
	logic [32:0] note[$];
	logic [31:0] q;
	logic [7:0]  b;

	tw_master tw_master_i (
		.clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .global_irq_enable(gie),
		.irq(irq), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
	);
	tw_slave tw_slave_i (
		.scl(scl), .sda(sda), .nak(nak), .sda_oe_n(s_oe_n), .rx(rx),
		.stop_seen(stop_seen)
	);

	initial begin
		forever #2 clock = ~clock;
	end

	task automatic stop_test;
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Reads leave their expectation in the queue for the watcher
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic c, output logic [31:0] r);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1 | 4'($urandom);
		dat <= {24'($urandom), d};
		if (!w)
			note.push_back({c, 24'h0, d});
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk("rd_upper", 0, {8'h0, r[31:8]});
	endtask

	always @(posedge clock) begin
		if (ack === 1'b1 && !we && note.size() > 0) begin
			if (note[0][32])
				chk("read_data", note[0][31:0], rdat);
			void'(note.pop_front());
		end
	end

	// Clearing write, poll for the flag, then check the posted code
	task automatic op(input logic [7:0] c, input logic [7:0] code,
		input logic ei);
		int n;
		n = 0;
		wb(1'b1, TW_ADDR_CTRL, c, 1'b0, q);
		#1;
		chk("irq_clear", 0, irq);
		do begin
			wb(1'b0, TW_ADDR_STATUS, 8'h00, 1'b0, q);
			n++;
		end while ((q[7:0] & 8'hf8) === 8'hf8 && n < 400);
		wb(1'b0, TW_ADDR_STATUS, code, 1'b1, q);
		wb(1'b0, TW_ADDR_CTRL, {7'h42, c[0]}, 1'b1, q);
		chk("irq", {31'h0, ei}, irq);
		repeat (60) @(posedge clock);
		chk("scl_low", 0, scl_oe_n);
	endtask

	initial begin
		void'($urandom(32'hf1410605));
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		wb(1'b0, TW_ADDR_STATUS, 8'hf8, 1'b1, q);
		wb(1'b0, TW_ADDR_DATA, TW_DATA_RESET, 1'b1, q);
		wb(1'b0, TW_ADDR_BITRT, TW_BITRT_RESET, 1'b1, q);
		wb(1'b0, 8'h10, 8'h00, 1'b1, q);
		// Quarter bit of 10 cycles gives a 160 ns link period
		wb(1'b1, TW_ADDR_BITRT, 8'h09, 1'b0, q);
		for (int t = 0; t < 3; t++) begin
			gie <= (t != 2);
			nak <= (t != 0);
			ie = (t != 1);
			op({7'h52, ie}, {TW_ST_START, 3'h0}, t == 0);
			wb(1'b1, TW_ADDR_CTRL, {7'h12, ie}, 1'b0, q);
			wb(1'b0, TW_ADDR_STATUS, {TW_ST_START, 3'h0}, 1'b1, q);
			b = {7'($urandom), 1'b0};
			wb(1'b1, TW_ADDR_DATA, b, 1'b0, q);
			wb(1'b0, TW_ADDR_DATA, b, 1'b1, q);
			op({7'h42, ie}, (t != 0) ? {TW_ST_ADDR_NAK, 3'h0} :
				{TW_ST_ADDR_ACK, 3'h0}, t == 0);
			chk("addr_byte", {24'h0, b}, {24'h0, rx});
			for (int k = 0; k < 2 && t == 0; k++) begin
				nak <= k[0];
				b = 8'($urandom);
				wb(1'b1, TW_ADDR_DATA, b, 1'b0, q);
				op({7'h42, ie}, (k != 0) ? {TW_ST_DATA_NAK, 3'h0} :
					{TW_ST_DATA_ACK, 3'h0}, 1'b1);
				chk("data_byte", {24'h0, b}, {24'h0, rx});
			end
			wb(1'b1, TW_ADDR_CTRL, {7'h4a, ie}, 1'b0, q);
			repeat (300) @(posedge clock);
			chk("stop", 1, stop_seen);
			wb(1'b0, TW_ADDR_STATUS, 8'hf8, 1'b1, q);
			wb(1'b0, TW_ADDR_CTRL, {7'h02, ie}, 1'b1, q);
			chk("irq_idle", 0, irq);
		end
		stop_test;
	end

	// Whole run is about 3500 cycles; this cuts a hang short
	initial begin
		#100000;
		error_cnt++;
		stop_test;
	end
endmodule
